// [inc/vrfs_pkg.sv]
/*
  package for the regulator fault supervisor: register map, field layout,
  timing constants, state enumeration, port structs.
  assumes a 100 MHz logic clock and a 32-bit AXI4-Lite register bus.
*/
package vrfs_pkg;
  // clock and timing
  localparam int CLK_HZ = 100_000_000;
  localparam int RETRY_WAIT_MS = 12;
  localparam int RETRY_WAIT_CYC = RETRY_WAIT_MS * (CLK_HZ / 1000);
  localparam logic [2:0] RETRY_LIMIT = 3'h7;
  localparam int NUM_CH = 4;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] RETRY_OFS = 8'h08;
  localparam logic [7:0] ID_OFS = 8'h0c;
  // control fields
  localparam int CTRL_PSI_BIT = 0;
  localparam int CTRL_PH34_BIT = 1;
  localparam int CTRL_NB_EN_BIT = 2;
  localparam logic [2:0] CTRL_RST = 3'h6;
  // status fields
  localparam int ST_PG_BIT = 0;
  localparam int ST_UV_BIT = 1;
  localparam int ST_OVL_BIT = 2;
  localparam int ST_OC_LAT_BIT = 3;
  localparam int ST_OPEN_BIT = 4;
  localparam int ST_SS_BIT = 5;
  localparam int ST_RUN_BIT = 6;
  localparam int ST_WAIT_BIT = 7;
  // identification value, arbitrary
  localparam logic [31:0] BLOCK_ID = 32'h0000_5a01;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_OFF, ST_SOFT, ST_RUN, ST_OC_WAIT, ST_OV_CLAMP, ST_LATCHED
  } vrfs_state_t;

  // comparator results from the analog front end
  typedef struct packed {
    logic core_uv_hi;            // core below target minus 300mV
    logic core_uv_lo;            // core below target minus 250mV
    logic nb_uv_hi;
    logic nb_uv_lo;
    logic ov;                    // overvoltage_trip on either output
    logic diff_out_low;          // differential output voltage below 400mV
    logic open_sense;
    logic core_oc100;
    logic core_oc140;
    logic nb_oc100;
    logic nb_oc140;
    logic [3:0] ch_oc140;        // per-channel current limit compare
  } vrfs_cmp_t;

  // gate and external drive commands
  typedef struct packed {
    logic [1:0] ug_core;
    logic [1:0] lg_core;
    logic ug_nb;
    logic lg_nb;
    logic [1:0] ext_pwm;         // phases 3 and 4 level
    logic [1:0] ext_pwm_oe_n;    // low = driven, high = high impedance
  } vrfs_drv_t;

  function automatic logic [2:0] sat_inc3(input logic [2:0] v);
    return (v == 3'h7) ? v : v + 3'h1;
  endfunction
endpackage

// [src/vrfs_top.sv]
/*
  fault supervisor for a dual buck controller: power good, overvoltage clamp,
  overcurrent hiccup with retry latch-off, open-sense restart, per-channel
  current limit, and an AXI4-Lite register slave.
  assumes comparator inputs arrive asynchronously, power-on reset and enable
  feed the asynchronous reset, and soft-start completion is reported by the
  ramp generator outside.
*/
`timescale 1ns/1ps
// Overview of operation
// - power good low until clean soft-start
// - power good low on any fault
// - latched faults hold power good low
// - overvoltage: lower gates on, drives low
// - clamp until below 400mV, repeat
// - overvoltage latch cleared only by reset
// - undervoltage pulls power good only
// - undervoltage clears at 250mV hysteresis
// - open sense: off, restart when cleared
// - average current above 100uA trips
// - soft-start uses raised 140uA level
// - core trip: gates low, phases 3-4 floated
// - wait 12ms then retry if enabled
// - seven failed retries latch off
// - completed soft-start clears retry count
// - northbridge trip disables northbridge only, except at latch-off
// - trip in power saving restarts normal
// - channel limit: upper low, lower high
// - upper held low until current falls
module vrfs_top #(
  parameter int RETRY_WAIT = vrfs_pkg::RETRY_WAIT_CYC
) (
  // clock and reset (power-on reset and enable combined)
  input wire logic CLK_SYS_I,
  input wire logic ARST_N_I,
  input wire logic ENABLE_I,
  // analog comparators and soft-start
  input wire vrfs_pkg::vrfs_cmp_t CMP_I,
  input wire logic SS_DONE_I,
  input wire logic [3:0] PWM_I,
  input wire logic PWM_NB_I,
  // outputs to drivers and system
  output vrfs_pkg::vrfs_drv_t DRV_O,
  output logic SS_START_O,
  output logic PSI_FORCE_O,
  output logic PG_O,
  output logic PG_OE_N_O,
  // axi4-lite slave
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I
);
  import vrfs_pkg::*;

  typedef struct packed {
    vrfs_cmp_t sync1;
    vrfs_cmp_t sync2;
    vrfs_state_t st;
    logic [23:0] wait_cnt;
    logic [2:0] retry;
    logic nb_only;
    logic uv_flag;
    logic ov_latched;
    logic oc_latched;
    logic psi_force;
    logic pg;
    logic [2:0] ctrl;
    logic [3:0] ch_block;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    vrfs_drv_t drv;
  } vrfs_regs_t;

  vrfs_regs_t s_q;
  vrfs_regs_t s_d;
  vrfs_cmp_t c;
  logic core_oc;
  logic nb_oc;
  logic [7:0] status;
  logic psi_trip;

  // synchronised comparator view and current trip selection
  always_comb begin
    c = s_q.sync2;
    core_oc = (s_q.st == ST_SOFT) ? c.core_oc140 : c.core_oc100;
    nb_oc = s_q.ctrl[CTRL_NB_EN_BIT] &&
            ((s_q.st == ST_SOFT) ? c.nb_oc140 : c.nb_oc100);
    // a trip in power saving mode; set by hardware, cleared by software
    // the set wins when both fall in one cycle
    psi_trip = (s_q.st == ST_SOFT || s_q.st == ST_RUN) && ENABLE_I && !c.ov &&
               !c.open_sense && (core_oc || nb_oc) && s_q.ctrl[CTRL_PSI_BIT];
    // status word for the register view
    status = {s_q.st == ST_OC_WAIT, s_q.st == ST_RUN, s_q.st == ST_SOFT,
              c.open_sense, s_q.oc_latched, s_q.ov_latched, s_q.uv_flag, s_q.pg};
  end

  // next-state logic
  always_comb begin
    s_d = s_q;

    // two-flop synchroniser; only the second stage feeds the logic
    s_d.sync1 = CMP_I;
    s_d.sync2 = s_q.sync1;

    // retry wait counter runs down to zero and parks there
    if (s_q.wait_cnt != 24'h0) begin
      s_d.wait_cnt = s_q.wait_cnt - 24'h1;
    end

    // undervoltage with hysteresis, either output
    if (c.core_uv_hi || (s_q.ctrl[CTRL_NB_EN_BIT] && c.nb_uv_hi)) begin
      s_d.uv_flag = 1'b1;
    end else if (!c.core_uv_lo && !(s_q.ctrl[CTRL_NB_EN_BIT] && c.nb_uv_lo)) begin
      s_d.uv_flag = 1'b0;
    end

    // fault sequencing
    case (s_q.st)
      ST_OFF: begin
        // leave off only when enabled and both sense lines are intact
        if (ENABLE_I && !c.open_sense) begin
          s_d.st = ST_SOFT;
        end
      end
      ST_SOFT, ST_RUN: begin
        // overvoltage outranks every other fault, then loss of sense or enable
        if (c.ov) begin
          s_d.st = ST_OV_CLAMP;
          s_d.ov_latched = 1'b1;
        end else if (c.open_sense || !ENABLE_I) begin
          s_d.st = ST_OFF;
        end else if (core_oc || nb_oc) begin
          // a trip with the count already at seven latches off
          s_d.nb_only = nb_oc && !core_oc;
          s_d.psi_force = s_q.psi_force | s_q.ctrl[CTRL_PSI_BIT];
          if (s_q.retry == RETRY_LIMIT) begin
            s_d.st = ST_LATCHED;
            s_d.oc_latched = 1'b1;
          end else begin
            s_d.st = ST_OC_WAIT;
            s_d.wait_cnt = 24'(RETRY_WAIT - 1);
          end
        end else if (s_q.st == ST_SOFT && SS_DONE_I) begin
          s_d.st = ST_RUN;
          s_d.retry = 3'h0;
        end
      end
      ST_OC_WAIT: begin
        // the tripped rail's gates stay off for the whole wait; overvoltage still clamps
        if (c.ov) begin
          s_d.st = ST_OV_CLAMP;
          s_d.ov_latched = 1'b1;
        end else if (s_q.wait_cnt == 24'h0) begin
          if (ENABLE_I) begin
            s_d.st = ST_SOFT;
            s_d.retry = sat_inc3(s_q.retry);
          end else begin
            s_d.st = ST_OFF;
          end
        end
      end
      ST_OV_CLAMP: begin
        // hold the low side on until the output has collapsed
        if (c.diff_out_low && !c.ov) begin
          s_d.st = ST_LATCHED;
        end
      end
      ST_LATCHED: begin
        // only reset leaves here; a new overvoltage clamps again
        if (c.ov) begin
          s_d.st = ST_OV_CLAMP;
        end
      end
      default: s_d.st = ST_OFF;
    endcase

    // power good: only in run with no fault of any kind
    // latched faults keep it low until reset and a fresh soft-start
    s_d.pg = (s_d.st == ST_RUN) && !s_d.uv_flag && !c.ov && !core_oc && !nb_oc
             && !s_q.ov_latched && !s_q.oc_latched;

    // per-channel current limit block
    // the block follows the comparator, so the upper gate returns once it falls
    for (int i = 0; i < NUM_CH; i++) begin
      s_d.ch_block[i] = c.ch_oc140[i];
    end

    // drive commands
    s_d.drv.ext_pwm_oe_n = {2{!s_q.ctrl[CTRL_PH34_BIT]}};
    s_d.drv.ext_pwm = PWM_I[3:2] & ~s_d.ch_block[3:2];
    s_d.drv.ug_core = PWM_I[1:0] & ~s_d.ch_block[1:0];
    s_d.drv.lg_core = ~PWM_I[1:0] | s_d.ch_block[1:0];
    s_d.drv.ug_nb = PWM_NB_I && s_q.ctrl[CTRL_NB_EN_BIT];
    s_d.drv.lg_nb = !PWM_NB_I && s_q.ctrl[CTRL_NB_EN_BIT];
    case (s_d.st)
      ST_OV_CLAMP: begin
        // every low side on, every high side and external phase low
        s_d.drv.ug_core = 2'h0;
        s_d.drv.lg_core = 2'h3;
        s_d.drv.ug_nb = 1'b0;
        s_d.drv.lg_nb = 1'b1;
        s_d.drv.ext_pwm = 2'h0;
      end
      ST_OC_WAIT: begin
        // a northbridge-only trip leaves the core switching
        if (s_d.nb_only) begin
          s_d.drv.ug_nb = 1'b0;
          s_d.drv.lg_nb = 1'b0;
        end else begin
          s_d.drv.ug_core = 2'h0;
          s_d.drv.lg_core = 2'h0;
          s_d.drv.ext_pwm = 2'h0;
          s_d.drv.ext_pwm_oe_n = 2'h3;
          s_d.drv.ug_nb = 1'b0;
          s_d.drv.lg_nb = 1'b0;
        end
      end
      ST_RUN, ST_SOFT: begin
        // modulator levels pass through as set up above
      end
      default: begin
        // off and latched: all gates low, external phases floated
        s_d.drv.ug_core = 2'h0;
        s_d.drv.lg_core = 2'h0;
        s_d.drv.ug_nb = 1'b0;
        s_d.drv.lg_nb = 1'b0;
        s_d.drv.ext_pwm = 2'h0;
        s_d.drv.ext_pwm_oe_n = 2'h3;
      end
    endcase

    // axi write channel
    if (S_AXI_AWVALID_I && !s_q.aw_got && !s_q.bvalid) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = S_AXI_AWADDR_I;
    end
    // data capture, independent of the address
    if (S_AXI_WVALID_I && !s_q.w_got && !s_q.bvalid) begin
      s_d.w_got = 1'b1;
      s_d.wdata = S_AXI_WDATA_I;
      s_d.wstrb = S_AXI_WSTRB_I;
    end

    // respond once both halves are in; readies stay low until it is taken
    if (s_q.aw_got && s_q.w_got) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      // register write decode; status and id ignore writes
      if (s_q.awaddr == CTRL_OFS) begin
        if (s_q.wstrb[0]) begin
          s_d.ctrl = s_q.wdata[2:0];
        end
      end else if (s_q.awaddr == RETRY_OFS) begin
        if (s_q.wstrb[0] && s_q.wdata[0] && !psi_trip) begin
          s_d.psi_force = 1'b0; // software acknowledges the forced exit
        end
      end else if (s_q.awaddr != STAT_OFS && s_q.awaddr != ID_OFS) begin
        s_d.bresp = RESP_SLVERR;
      end
    end else if (s_q.bvalid && S_AXI_BREADY_I) begin
      s_d.bvalid = 1'b0;
    end

    // axi read channel
    if (S_AXI_ARVALID_I && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      // read decode; unmapped offsets answer with an error and zero data
      if (S_AXI_ARADDR_I == CTRL_OFS) begin
        s_d.rdata = {29'h0, s_q.ctrl};
      end else if (S_AXI_ARADDR_I == STAT_OFS) begin
        s_d.rdata = {24'h0, status};
      end else if (S_AXI_ARADDR_I == RETRY_OFS) begin
        s_d.rdata = {27'h0, s_q.psi_force, s_q.nb_only, s_q.retry};
      end else if (S_AXI_ARADDR_I == ID_OFS) begin
        s_d.rdata = BLOCK_ID;
      end else begin
        s_d.rdata = 32'h0;
        s_d.rresp = RESP_SLVERR;
      end
    end else if (s_q.rvalid && S_AXI_RREADY_I) begin
      s_d.rvalid = 1'b0;
    end
  end

  // state register; reset holds everything off, power good low
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      // everything clear, then the few fields that reset non-zero
      s_q <= '0;
      s_q.st <= ST_OFF;
      s_q.ctrl <= CTRL_RST;
      s_q.drv.ext_pwm_oe_n <= 2'h3;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs; power good is open drain, enable low while pulling low
  always_comb begin
    // driver and system outputs
    DRV_O = s_q.drv;
    SS_START_O = (s_q.st == ST_SOFT);
    PSI_FORCE_O = s_q.psi_force;
    PG_O = 1'b0;
    PG_OE_N_O = s_q.pg;
    // bus handshake from registered state
    S_AXI_AWREADY_O = !s_q.aw_got && !s_q.bvalid;
    S_AXI_WREADY_O = !s_q.w_got && !s_q.bvalid;
    S_AXI_BVALID_O = s_q.bvalid;
    S_AXI_BRESP_O = s_q.bresp;
    S_AXI_ARREADY_O = !s_q.rvalid;
    S_AXI_RVALID_O = s_q.rvalid;
    S_AXI_RDATA_O = s_q.rdata;
    S_AXI_RRESP_O = s_q.rresp;
  end
endmodule // vrfs_top

// [test/vr_fault_supervisor_tb_top.sv]
/*
  testbench for the fault supervisor: scenario tasks and an AXI4-Lite master.
  assumes vrfs_top, vrfs_partner and vrfs_asserts are compiled before it.
*/
`timescale 1ns/1ps
module vr_fault_supervisor_tb_top;
  import vrfs_pkg::*;
  localparam int RW = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic en = 1'b1;
  logic slow = 1'b0;
  logic ss_done, ss_st, psi_f, pg, pg_oe_n, pg_w, awr, wr, bv, arr, rv;
  vrfs_cmp_t cmp = '0;
  vrfs_drv_t drv;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd;
  logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic [1:0] br, rr;
  int failures = 0, num_checks = 0, k, n;
  // clock
  always #5 clk = ~clk;
  vrfs_top #(.RETRY_WAIT(RW)) u_dut (.CLK_SYS_I(clk), .ARST_N_I(rst_n), .ENABLE_I(en),
    .CMP_I(cmp), .SS_DONE_I(ss_done), .PWM_I(4'hf), .PWM_NB_I(1'b1), .DRV_O(drv),
    .SS_START_O(ss_st), .PSI_FORCE_O(psi_f), .PG_O(pg), .PG_OE_N_O(pg_oe_n),
    .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
    .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr),
    .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bre),
    .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
    .S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rre));
  vrfs_partner u_part (.clk_i(clk), .rst_n_i(rst_n), .ss_start_i(ss_st), .slow_i(slow),
    .ss_done_o(ss_done), .pg_i(pg), .pg_oe_n_i(pg_oe_n), .pg_wire_o(pg_w));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // waits end at a falling edge where outputs are settled
  task automatic wc(input int c);
    repeat (c) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic wss(input logic v, output int c);
    c = 0;
    while (ss_st !== v && c < 200) begin
      @(negedge clk);
      c++;
    end
  endtask
  task automatic wrt(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic at, wt, bt;
    bt = 1'b0;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    while (!bt) begin
      @(negedge clk);
      at = awv && awr;
      wt = wv && wr;
      bt = bv;
      if (bt) chk(br, r);
      @(posedge clk);
      if (at) awv <= 1'b0;
      if (wt) wv <= 1'b0;
    end
    bre <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    logic at, bt;
    bt = 1'b0;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    while (!bt) begin
      @(negedge clk);
      at = arv && arr;
      bt = rv;
      if (bt) chk({rr, rd}, {r, e});
      @(posedge clk);
      if (at) arv <= 1'b0;
    end
    rre <= 1'b0;
  endtask
  // reset, then a full soft-start into regulation
  task automatic boot;
    @(posedge clk);
    rst_n <= 1'b0;
    cmp <= '0;
    en <= 1'b1;
    wc(16);
    chk(pg_w, 0);
    @(posedge clk);
    rst_n <= 1'b1;
    wss(1, k);
    chk(pg_w, 0);
    wss(0, k);
    wc(3);
    chk(pg_w, 1);
  endtask
  task automatic t_regs;
    rchk(ID_OFS, BLOCK_ID, RESP_OKAY);
    rchk(CTRL_OFS, {29'h0, CTRL_RST}, RESP_OKAY);
    rchk(8'h40, 32'h0, RESP_SLVERR);
    wrt(8'h40, 32'h0, RESP_SLVERR);
    rchk(STAT_OFS, 32'h41, RESP_OKAY);
  endtask
  task automatic t_uv;
    @(posedge clk);
    cmp.core_uv_hi <= 1'b1;
    cmp.core_uv_lo <= 1'b1;
    wc(1);
    chk(pg_w, 1);
    wc(4);
    rchk(STAT_OFS, 32'h42, RESP_OKAY);
    @(posedge clk);
    cmp.core_uv_hi <= 1'b0;
    wc(5);
    chk(pg_w, 0);
    @(posedge clk);
    cmp.core_uv_lo <= 1'b0;
    wc(5);
    chk(pg_w, 1);
  endtask
  task automatic t_ov;
    boot();
    @(posedge clk);
    cmp.ov <= 1'b1;
    wc(5);
    chk({drv.lg_core, drv.ug_core, drv.ext_pwm, pg_w}, 7'h60);
    @(posedge clk);
    cmp <= '{ov: 1'b0, diff_out_low: 1'b1, default: 1'b0};
    wc(5);
    @(posedge clk);
    cmp <= '{ov: 1'b1, default: 1'b0};
    wc(8);
    chk(drv.lg_core, 2'h3);
    @(posedge clk);
    cmp <= '{diff_out_low: 1'b1, default: 1'b0};
    wss(1, k);
    chk(k, 200);
    chk(pg_w, 0);
  endtask
  task automatic t_oc;
    boot();
    slow <= 1'b1;
    wrt(CTRL_OFS, 32'h7, RESP_OKAY);
    @(posedge clk);
    cmp.core_oc100 <= 1'b1;
    wc(4);
    chk({drv.ug_core, drv.lg_core, drv.ext_pwm_oe_n, pg_w}, 7'h06);
    chk(psi_f, 1);
    wss(1, k);
    chk(k >= RW - 4 && k <= RW + 4, 1);
    wc(30);
    chk(ss_st, 1);
    @(posedge clk);
    cmp.core_oc100 <= 1'b0;
    slow <= 1'b0;
    wss(0, k);
    wc(3);
    rchk(RETRY_OFS, 32'h10, RESP_OKAY);
    wrt(RETRY_OFS, 32'h1, RESP_OKAY);
    rchk(RETRY_OFS, 32'h0, RESP_OKAY);
  endtask
  task automatic t_trip(input logic hard);
    boot();
    @(posedge clk);
    cmp.core_oc100 <= 1'b1;
    cmp.core_oc140 <= hard;
    n = 0;
    repeat (9) begin
      wss(1, k);
      n += (k < 200);
      wss(0, k);
    end
    chk(n, hard ? 7 : 9);
    wc(2);
    chk({drv.ug_core, drv.lg_core, drv.ug_nb, drv.lg_nb, pg_w}, 0);
  endtask
  task automatic t_chnb;
    boot();
    @(posedge clk);
    cmp.ch_oc140 <= 4'h1;
    wc(4);
    chk({drv.ug_core[0], drv.lg_core[0], pg_w}, 3'h3);
    wc(10);
    chk(drv.ug_core[0], 0);
    @(posedge clk);
    cmp.ch_oc140 <= 4'h0;
    cmp.nb_oc100 <= 1'b1;
    wc(4);
    chk({drv.ug_nb, drv.lg_nb, pg_w, drv.ug_core}, 5'h03);
  endtask
  task automatic t_open;
    boot();
    @(posedge clk);
    cmp.open_sense <= 1'b1;
    wc(5);
    chk({pg_w, ss_st}, 0);
    wss(1, k);
    chk(k, 200);
    @(posedge clk);
    cmp.open_sense <= 1'b0;
    wss(1, k);
    chk(k < 20, 1);
    wss(0, k);
    chk(pg_w, 1);
    @(posedge clk);
    en <= 1'b0;
    wc(5);
    chk(pg_w, 0);
  endtask
  task automatic print_verdict;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // main sequence
  initial begin
    boot();
    t_regs();
    t_uv();
    t_ov();
    t_oc();
    t_trip(1'b0);
    t_trip(1'b1);
    t_chnb();
    t_open();
    print_verdict();
  end
  // watchdog against a hang
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    print_verdict();
  end
endmodule // vr_fault_supervisor_tb_top
bind vrfs_top vrfs_asserts #(.RETRY_WAIT(RETRY_WAIT)) u_chk (.CLK_SYS_I(CLK_SYS_I),
  .ARST_N_I(ARST_N_I), .ENABLE_I(ENABLE_I), .CMP_I(CMP_I), .DRV_O(DRV_O),
  .SS_START_O(SS_START_O), .PG_OE_N_O(PG_OE_N_O));

// [test/vrfs_asserts.sv]
/*
  port checker for the fault supervisor.
  assumes a bind onto vrfs_top and one clock domain.
*/
`timescale 1ns/1ps
module vrfs_asserts #(
  parameter int RETRY_WAIT = 20
) (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic ARST_N_I,
  input wire logic ENABLE_I,
  // watched signals
  input wire vrfs_pkg::vrfs_cmp_t CMP_I,
  input wire vrfs_pkg::vrfs_drv_t DRV_O,
  input wire logic SS_START_O,
  input wire logic PG_OE_N_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!ARST_N_I);
  // clamp and off drive patterns, undervoltage set sequence
  sequence s_clamp;
    DRV_O.lg_core == 2'h3 && DRV_O.ug_core == 2'h0 && DRV_O.ext_pwm == 2'h0 && !PG_OE_N_O;
  endsequence
  sequence s_off;
    DRV_O.ug_core == 2'h0 && DRV_O.lg_core == 2'h0 && DRV_O.ext_pwm_oe_n == 2'h3 && !PG_OE_N_O;
  endsequence
  sequence s_uv_set;
    $rose(CMP_I.core_uv_hi) ##1 CMP_I.core_uv_lo [*4];
  endsequence
  AST_PG_SOFT: assert property (SS_START_O |-> !PG_OE_N_O)
    else $error("pg released in soft-start");
  AST_EN_OFF: assert property ($fell(ENABLE_I) |-> ##[1:4] !PG_OE_N_O)
    else $error("pg kept after disable");
  AST_OV_CLAMP: assert property ($rose(CMP_I.ov) |-> ##[1:4] s_clamp)
    else $error("no clamp on overvoltage");
  AST_OV_HOLD: assert property ((CMP_I.ov && !CMP_I.diff_out_low) [*5] |-> s_clamp)
    else $error("clamp dropped early");
  AST_UV_PG: assert property ($rose(CMP_I.core_uv_hi) |-> ##[1:4] !PG_OE_N_O)
    else $error("pg kept on undervoltage");
  AST_UV_HYST: assert property (s_uv_set |-> !PG_OE_N_O)
    else $error("undervoltage cleared early");
  AST_OC_SHUT: assert property ($rose(CMP_I.core_oc100) && PG_OE_N_O |-> ##[1:4] s_off)
    else $error("bad overcurrent shutdown");
  AST_OPEN: assert property ($rose(CMP_I.open_sense) |-> ##[1:4] !PG_OE_N_O && !SS_START_O)
    else $error("open sense not shut down");
  AST_CH_LIM: assert property (CMP_I.ch_oc140[0] [*5] |-> !DRV_O.ug_core[0])
    else $error("upper gate high in limit");
endmodule // vrfs_asserts

// [test/vrfs_partner.sv]
/*
  far side model: soft-start ramp generator and the pulled-up power good wire.
  assumes the ramp starts while ss_start_i is high and reports done once.
*/
`timescale 1ns/1ps
module vrfs_partner (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // ramp control
  input wire logic ss_start_i,
  input wire logic slow_i,
  output logic ss_done_o,
  // power good pin
  input wire logic pg_i,
  input wire logic pg_oe_n_i,
  output logic pg_wire_o
);
  logic [5:0] cnt_q;
  // ramp length counter, short or long ramp
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      cnt_q <= 6'h00;
    else
      cnt_q <= ss_start_i ? cnt_q + 6'h01 : 6'h00;
  end
  assign ss_done_o = ss_start_i && (cnt_q == (slow_i ? 6'h28 : 6'h08));
  // resistor pulls the released wire high
  assign pg_wire_o = pg_oe_n_i ? 1'b1 : pg_i;
endmodule // vrfs_partner
